/* rtl/an_arb_pkg.sv */
// package: constants and types for the base-page negotiation arbiter
package an_arb_pkg;

    // config word bit positions
    localparam int FD_BIT = 5;
    localparam int HD_BIT = 6;
    localparam int PS1_BIT = 7;
    localparam int PS2_BIT = 8;
    localparam int RF_LO = 12;
    localparam int RF_HI = 13;
    localparam int ACK_BIT = 14;
    localparam int NP_BIT = 15;
    localparam logic [15:0] ABIL_MASK = 16'h01E0;

    // remote fault codes
    localparam logic [1:0] RF_OK = 2'h0;
    localparam logic [1:0] RF_OFFLINE = 2'h1;
    localparam logic [1:0] RF_LINKFAIL = 2'h2;
    localparam logic [1:0] RF_ANERR = 2'h3;

    // register byte offsets
    localparam logic [11:0] ADV_OFS = 12'h000;
    localparam logic [11:0] NPTX_OFS = 12'h004;
    localparam logic [11:0] CTRL_OFS = 12'h008;
    localparam logic [11:0] STAT_OFS = 12'h00C;
    localparam logic [11:0] LPA_OFS = 12'h010;
    localparam logic [11:0] RES_OFS = 12'h014;

    // control bits
    localparam int CTRL_RESTART = 0;
    localparam int CTRL_NPLOAD = 1;
    localparam int CTRL_FAULTCAP = 2;
    localparam logic [15:0] ADV_RESET = 16'h01A0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0004;

    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int LINK_TIMER_US = 10;
    localparam int LINK_TIMER_CYC = LINK_TIMER_US * (CLK_HZ / 1_000_000);
    localparam int RESTART_WORDS = 4;
    localparam int MATCH_COUNT = 3;

    typedef enum logic [1:0] {
        XMIT_IDLE,
        XMIT_CONFIG,
        XMIT_DATA
    } xmit_e;

    typedef enum logic [1:0] {
        RX_NONE,
        RX_CFG,
        RX_IDL,
        RX_INVALID
    } rxind_e;

    typedef struct packed {
        logic valid;
        logic isCfg;
        logic isIdle;
        logic codeErr;
        logic [15:0] word;
    } rx_set_s;

    typedef struct packed {
        logic pauseTx;
        logic pauseRx;
        logic fullDuplex;
        logic halfDuplex;
        logic noCommon;
    } res_s;

endpackage

/* rtl/serdes_link_autoneg_arbiter.sv */
// auto-negotiation arbiter: tx/rx config words, arbitration, resolution
// Operation
// - remote fault code in D13:D12, default zero
// - fault codes: ok, offline, link fail, neg error
// - no fault capability means advertise zero
// - hold fault code until idle detect, clear; kept there instead when next pages were exchanged
// - received nonzero fault sets status bit
// - withhold fault signalling while sync fails
// - unusable resolution advertises negotiation error
// - ack after four matching words in a row, ack masked
// - next page ack held until page loaded
// - complete-ack sends word for link timer
// - next page bit requests more pages
// - restart sends zero words then base page
// - never advertise abilities not possessed
// - tx word from adv or next page register
// - xmit selects config, idle or data sets
// - receiver stores decoded config word content
// - derive ability, ack, consistency, idle matches
// - flag config, idle, invalid indications
// - renegotiation restarts from enable state
// - full duplex beats half duplex
// - pause resolution by fixed mapping
// - full duplex D5, half duplex D6
// - pause D7, asymmetric D8
`timescale 1ns/1ps
`default_nettype none

module serdes_link_autoneg_arbiter #(
    parameter int LINK_TIMER = an_arb_pkg::LINK_TIMER_CYC,
    parameter logic [15:0] LOCAL_ABIL = an_arb_pkg::ABIL_MASK
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // coding sublayer receive side
    input wire an_arb_pkg::rx_set_s rxSet,
    input wire logic syncOk,
    input wire logic faultSensed,
    input wire logic [1:0] faultCode,
    // coding sublayer transmit side
    output an_arb_pkg::xmit_e xmit,
    output logic [15:0] txConfigWord,
    output an_arb_pkg::rxind_e rxIndication,
    // resolved mode
    output an_arb_pkg::res_s resolved,
    output logic anComplete
);

    typedef enum logic [2:0] {
        AN_ENABLE,
        AN_RESTART,
        ABILITY_DETECT,
        ACK_DETECT,
        COMPLETE_ACK,
        NEXT_PAGE_WAIT,
        IDLE_DETECT,
        LINK_OK
    } an_state_e;

    ////////////////////////////////////////////////////////////////////////
    // registers

    an_state_e state;
    logic [15:0] adv;
    logic [15:0] npTx;
    logic npLoaded;
    logic faultCap;
    logic [1:0] rfCode;
    logic rfStatus;
    logic [15:0] lpWord;
    logic [15:0] lastWord;
    logic [1:0] matchCnt;
    logic [1:0] idleCnt;
    logic [31:0] timer;
    logic [2:0] zeroCnt;
    logic inNextPage;
    logic ackOut;

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    wire busWr = psel && penable && pwrite;
    wire selAdv = paddr == an_arb_pkg::ADV_OFS;
    wire selNp = paddr == an_arb_pkg::NPTX_OFS;
    wire selCtrl = paddr == an_arb_pkg::CTRL_OFS;
    wire selStat = paddr == an_arb_pkg::STAT_OFS;
    wire selLpa = paddr == an_arb_pkg::LPA_OFS;
    wire selRes = paddr == an_arb_pkg::RES_OFS;
    wire mapped = selAdv || selNp || selCtrl || selStat || selLpa || selRes;
    wire restartReq = busWr && selCtrl && pwdata[an_arb_pkg::CTRL_RESTART];
    wire npLoadReq = busWr && selNp;

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    ////////////////////////////////////////////////////////////////////////
    // receive side match logic

    wire cfgRx = rxSet.valid && rxSet.isCfg;
    wire idleRx = rxSet.valid && rxSet.isIdle;
    wire [15:0] noAck = rxSet.word & ~(16'h0001 << an_arb_pkg::ACK_BIT);
    wire [15:0] lastNoAck = lastWord & ~(16'h0001 << an_arb_pkg::ACK_BIT);
    wire sameWord = cfgRx && (noAck == lastNoAck);
    wire abilityMatch = sameWord &&
        (matchCnt == 2'(an_arb_pkg::MATCH_COUNT - 1));
    wire ackMatch = abilityMatch && rxSet.word[an_arb_pkg::ACK_BIT];
    wire consistMatch = (lpWord & ~(16'h0001 << an_arb_pkg::ACK_BIT)) ==
        noAck;
    wire idleMatch = idleRx && (idleCnt == 2'(an_arb_pkg::MATCH_COUNT - 1));
    wire timerDone = timer >= 32'(LINK_TIMER);

    ////////////////////////////////////////////////////////////////////////
    // priority resolution

    wire [15:0] advMasked = adv & LOCAL_ABIL;
    wire lPs1 = advMasked[an_arb_pkg::PS1_BIT];
    wire lPs2 = advMasked[an_arb_pkg::PS2_BIT];
    wire pPs1 = lpWord[an_arb_pkg::PS1_BIT];
    wire pPs2 = lpWord[an_arb_pkg::PS2_BIT];
    wire bothFd = advMasked[an_arb_pkg::FD_BIT] && lpWord[an_arb_pkg::FD_BIT];
    wire bothHd = advMasked[an_arb_pkg::HD_BIT] && lpWord[an_arb_pkg::HD_BIT];
    an_arb_pkg::res_s next_resolved;
    always_comb begin
        next_resolved.fullDuplex = bothFd;
        next_resolved.halfDuplex = bothHd && !bothFd;
        next_resolved.noCommon = !bothFd && !bothHd;
        next_resolved.pauseTx = (lPs1 && pPs1) ||
            (!lPs1 && lPs2 && pPs1 && pPs2);
        next_resolved.pauseRx = (lPs1 && pPs1) ||
            (lPs1 && lPs2 && !pPs1 && pPs2);
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit word

    // fault is only sent once sync is good; stored meanwhile
    wire [1:0] rfSent = (faultCap && syncOk) ? rfCode :
        an_arb_pkg::RF_OK;
    wire [15:0] baseWord = {advMasked[an_arb_pkg::NP_BIT], ackOut, rfSent,
        advMasked[11:0]};
    wire [15:0] npWord = {npTx[15], ackOut, npTx[13:0]};
    // zeros from the restart request on, so no base page leaks out early
    wire sendZero = state == AN_ENABLE || state == AN_RESTART || restartReq;
    wire [15:0] next_txWord = sendZero ? 16'h0000 :
        (inNextPage ? npWord : baseWord);

    ////////////////////////////////////////////////////////////////////////
    // arbitration state machine

    an_state_e next_state;
    always_comb begin
        next_state = state;
        case (state)
            AN_ENABLE: begin
                next_state = AN_RESTART;
            end
            AN_RESTART: begin
                if (zeroCnt == 3'(an_arb_pkg::RESTART_WORDS)) begin
                    next_state = ABILITY_DETECT;
                end
            end
            ABILITY_DETECT: begin
                if (abilityMatch && noAck != 16'h0000) begin
                    next_state = ACK_DETECT;
                end
            end
            ACK_DETECT: begin
                if (ackMatch && consistMatch) begin
                    next_state = COMPLETE_ACK;
                end else if (ackMatch) begin
                    next_state = AN_ENABLE;
                end
            end
            COMPLETE_ACK: begin
                if (timerDone) begin
                    if (advMasked[an_arb_pkg::NP_BIT] &&
                        lpWord[an_arb_pkg::NP_BIT]) begin
                        next_state = NEXT_PAGE_WAIT;
                    end else begin
                        next_state = IDLE_DETECT;
                    end
                end
            end
            NEXT_PAGE_WAIT: begin
                if (npLoaded && !npTx[15] && !lpWord[an_arb_pkg::NP_BIT]) begin
                    next_state = IDLE_DETECT;
                end else if (npLoaded && abilityMatch) begin
                    next_state = ACK_DETECT;
                end
            end
            IDLE_DETECT: begin
                if (idleMatch && timerDone) begin
                    next_state = LINK_OK;
                end
            end
            default: begin
                if (abilityMatch) begin
                    next_state = AN_ENABLE;
                end
            end
        endcase
        if (restartReq) begin
            next_state = AN_ENABLE;
        end
    end

    wire stateChange = next_state != state;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state <= AN_ENABLE;
            timer <= '0;
            zeroCnt <= '0;
        end else begin
            state <= next_state;
            timer <= stateChange ? 32'h0000_0000 : timer + 32'h0000_0001;
            zeroCnt <= (state == AN_RESTART && cfgRx) ? zeroCnt + 3'h1 :
                (state == AN_RESTART ? zeroCnt : 3'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive tracking and ack

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            lastWord <= '0;
            matchCnt <= '0;
            idleCnt <= '0;
            lpWord <= '0;
            ackOut <= 1'b0;
            inNextPage <= 1'b0;
        end else begin
            if (cfgRx) begin
                lastWord <= rxSet.word;
                matchCnt <= sameWord ? (matchCnt == 2'h2 ? matchCnt :
                    matchCnt + 2'h1) : 2'h0;
            end
            idleCnt <= idleRx ? (idleCnt == 2'h2 ? idleCnt : idleCnt + 2'h1) :
                (cfgRx ? 2'h0 : idleCnt);
            if (state == ABILITY_DETECT && abilityMatch) begin
                lpWord <= rxSet.word;
            end
            if (next_state == ACK_DETECT && state != ACK_DETECT) begin
                ackOut <= 1'b1;
            end else if (state == AN_ENABLE ||
                (state == NEXT_PAGE_WAIT && npLoaded)) begin
                ackOut <= 1'b0;
            end
            if (state == AN_ENABLE) begin
                inNextPage <= 1'b0;
            end else if (next_state == NEXT_PAGE_WAIT) begin
                inNextPage <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fault and register state

    wire rfClear = next_state == IDLE_DETECT && state != IDLE_DETECT &&
        !inNextPage;
    wire rxFault = state == ABILITY_DETECT && abilityMatch &&
        rxSet.word[an_arb_pkg::RF_HI:an_arb_pkg::RF_LO] != an_arb_pkg::RF_OK;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            adv <= an_arb_pkg::ADV_RESET;
            npTx <= '0;
            npLoaded <= 1'b0;
            faultCap <= an_arb_pkg::CTRL_RESET[an_arb_pkg::CTRL_FAULTCAP];
            rfCode <= an_arb_pkg::RF_OK;
            rfStatus <= 1'b0;
        end else begin
            if (busWr && selAdv) begin
                adv <= pwdata[15:0];
            end
            if (npLoadReq) begin
                npTx <= pwdata[15:0];
            end
            npLoaded <= npLoadReq ? 1'b1 :
                ((state == NEXT_PAGE_WAIT && npLoaded) ? 1'b0 : npLoaded);
            if (busWr && selCtrl) begin
                faultCap <= pwdata[an_arb_pkg::CTRL_FAULTCAP];
            end
            // later cause wins, clear at idle detect unless next pages were exchanged
            if (state == ACK_DETECT && next_state == COMPLETE_ACK &&
                next_resolved.noCommon) begin
                rfCode <= an_arb_pkg::RF_ANERR;
            end else if (faultSensed && faultCode != an_arb_pkg::RF_OK) begin
                rfCode <= faultCode;
            end else if (rfClear) begin
                rfCode <= an_arb_pkg::RF_OK;
            end
            if (rxFault) begin
                rfStatus <= 1'b1;
            end else if (psel && penable && !pwrite && selStat) begin
                rfStatus <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            xmit <= an_arb_pkg::XMIT_CONFIG;
            txConfigWord <= '0;
            rxIndication <= an_arb_pkg::RX_NONE;
            resolved <= '0;
            anComplete <= 1'b0;
        end else begin
            xmit <= (next_state == LINK_OK) ? an_arb_pkg::XMIT_DATA :
                (next_state == IDLE_DETECT ? an_arb_pkg::XMIT_IDLE :
                an_arb_pkg::XMIT_CONFIG);
            txConfigWord <= next_txWord;
            rxIndication <= !rxSet.valid ? an_arb_pkg::RX_NONE :
                ((rxSet.codeErr && xmit == an_arb_pkg::XMIT_CONFIG) ?
                an_arb_pkg::RX_INVALID : (rxSet.isCfg ? an_arb_pkg::RX_CFG :
                (rxSet.isIdle ? an_arb_pkg::RX_IDL : an_arb_pkg::RX_NONE)));
            if (state == COMPLETE_ACK) begin
                resolved <= next_resolved;
            end
            anComplete <= next_state == LINK_OK;
        end
    end

    wire [31:0] statWord = {28'h0, anComplete, 1'b0, rfStatus,
        state == LINK_OK};
    wire [31:0] ctrlWord = {29'h0, faultCap, npLoaded, 1'b0};
    wire [31:0] resWord = {27'h0, resolved};
    assign prdata = selAdv ? {16'h0, advMasked} :
        selNp ? {16'h0, npTx} :
        selCtrl ? ctrlWord :
        selStat ? statWord :
        selLpa ? {16'h0, lpWord} :
        selRes ? resWord : 32'h0000_0000;

endmodule

`default_nettype wire

/* verification/an_arb_sva.sv */
// checker: port-level properties of the negotiation arbiter
`timescale 1ns/1ps
`default_nettype none
module an_arb_sva #(
    parameter logic [15:0] LOCAL_ABIL = 16'h01E0
) (
    // clock, reset, bus
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // link side
    input wire an_arb_pkg::rx_set_s rxSet,
    input wire logic syncOk,
    input wire an_arb_pkg::xmit_e xmit,
    input wire logic [15:0] txConfigWord,
    input wire an_arb_pkg::rxind_e rxIndication,
    input wire an_arb_pkg::res_s resolved,
    input wire logic anComplete
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence cfgIn;
        rxSet.valid && rxSet.isCfg && !rxSet.codeErr;
    endsequence
    sequence syncLost;
        !syncOk [*2];
    endsequence
    a_rx_cfg: assert property (cfgIn |=> rxIndication == an_arb_pkg::RX_CFG)
        else $error("config set not flagged");
    a_rx_idle: assert property (rxSet.valid && rxSet.isIdle && !rxSet.isCfg
        && !rxSet.codeErr |=> rxIndication == an_arb_pkg::RX_IDL)
        else $error("idle set not flagged");
    a_rx_invalid: assert property (rxSet.valid && rxSet.codeErr && xmit ==
        an_arb_pkg::XMIT_CONFIG |=> rxIndication == an_arb_pkg::RX_INVALID)
        else $error("coding error not flagged");
    a_rx_quiet: assert property (!rxSet.valid |=> rxIndication == an_arb_pkg::RX_NONE)
        else $error("indication without a set");
    a_restart_zero: assert property ($rose(rst_b) |-> txConfigWord == 16'h0000
        && xmit == an_arb_pkg::XMIT_CONFIG)
        else $error("restart word not zero");
    a_abil_mask: assert property (((txConfigWord & ~LOCAL_ABIL)
        & 16'h0FFF) == 16'h0000)
        else $error("unowned ability advertised");
    a_sync_hold: assert property (syncLost |-> txConfigWord[13:12] == 2'h0)
        else $error("fault sent while sync lost");
    a_link_data: assert property (anComplete |-> xmit == an_arb_pkg::XMIT_DATA)
        else $error("link up without data mode");
    a_fd_first: assert property (resolved.fullDuplex |-> !resolved.halfDuplex)
        else $error("both duplex modes resolved");
    a_apb_ready: assert property (psel && penable |-> pready)
        else $error("access phase not ready");
    a_apb_err: assert property (psel && penable && paddr > 12'h014 |-> pslverr)
        else $error("unmapped access not refused");
endmodule
bind serdes_link_autoneg_arbiter an_arb_sva #(.LOCAL_ABIL(LOCAL_ABIL))
    an_arb_sva_i (.clk_sys, .rst_b, .psel, .penable, .paddr, .pready,
    .pslverr, .rxSet, .syncOk, .xmit, .txConfigWord, .rxIndication,
    .resolved, .anComplete);
`default_nettype wire

/* verification/link_partner_model.sv */
// partner model: far-end negotiation logic feeding received sets
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // near end transmit side
    input wire an_arb_pkg::xmit_e xmit,
    input wire logic [15:0] txConfigWord,
    // scenario controls
    input wire logic [15:0] abil,
    input wire logic [2:0] gap,
    input wire logic injectErr,
    // sets toward the near end, last base page heard
    output an_arb_pkg::rx_set_s rxSet,
    output logic [15:0] seenWord
);
    logic [2:0] tick;
    logic [1:0] same;
    logic cfg;
    logic [15:0] heard;
    assign cfg = (xmit == an_arb_pkg::XMIT_CONFIG);
    assign heard = txConfigWord & 16'hBFFF;
    always_ff @(posedge clk_sys) begin
        tick <= tick + 3'h1;
        rxSet.valid <= 1'b0;
        // between sets the word field is inverted every cycle
        rxSet.word <= ~rxSet.word;
        if (!rst_b) begin
            rxSet <= '0;
            tick <= 3'h0;
            same <= 2'h0;
            seenWord <= 16'h0000;
        end else if (tick >= gap) begin
            tick <= 3'h0;
            rxSet.valid <= 1'b1;
            rxSet.isCfg <= cfg;
            rxSet.isIdle <= !cfg;
            rxSet.codeErr <= injectErr;
            // next page bit kept clear: the model declines extra pages
            rxSet.word <= cfg ? {1'b0, same == 2'h3, abil[13:0]} : 16'h0;
            if (!cfg || heard == 16'h0000) begin
                same <= 2'h0;
            end else if (heard != seenWord) begin
                same <= 2'h1;
            end else if (same != 2'h3) begin
                same <= same + 2'h1;
            end
            if (cfg && heard != 16'h0000) begin
                seenWord <= heard;
            end
        end
    end
endmodule
`default_nettype wire

/* verification/tb_serdes_link_autoneg_arbiter.sv */
// testbench: arbiter against the partner model and a reference model
`timescale 1ns/1ps
`default_nettype none
module tb_serdes_link_autoneg_arbiter;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic syncOk = 1'b1;
    logic faultSensed = 1'b0;
    logic injectErr = 1'b0;
    logic [1:0] faultCode = 2'h0;
    logic [15:0] pAbil = 16'h0060;
    logic [2:0] gap = 3'h1;
    int anErrSeen = 0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, errBit, anComplete;
    logic [15:0] txConfigWord, seenWord;
    an_arb_pkg::rx_set_s rxSet;
    an_arb_pkg::xmit_e xmit;
    an_arb_pkg::rxind_e rxIndication;
    an_arb_pkg::res_s resolved;
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;
    int seed = 87196;
    // short link timer keeps each negotiation brief
    serdes_link_autoneg_arbiter #(.LINK_TIMER(20)) serdes_link_autoneg_arbiter_i (
        .clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rxSet, .syncOk, .faultSensed, .faultCode, .xmit,
        .txConfigWord, .rxIndication, .resolved, .anComplete);
    link_partner_model link_partner_model_i (.clk_sys, .rst_b, .xmit,
        .txConfigWord, .abil(pAbil), .gap, .injectErr, .rxSet, .seenWord);
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (txConfigWord[13:12] === 2'h3) anErrSeen <= anErrSeen + 1;
        if (cycles == 60000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // request held until the edge at which pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        // taken at the accepting edge, before any design update lands
        rd = prdata;
        errBit = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic waitLink(input logic lvl);
        int i;
        i = 0;
        do @(negedge clk_sys); while (anComplete !== lvl && ++i < 3000);
        @(posedge clk_sys);
        if (i >= 3000) check(32'h0, 32'h1);
    endtask
    task automatic run(input logic [15:0] adv, input logic [15:0] pa,
                       input logic [3:0] ctl, input logic [1:0] rf);
        logic fd, hd, tx, rx;
        pAbil <= pa;
        gap <= 3'h1 + {1'b0, 2'($random(seed))};
        apb(1'b1, an_arb_pkg::ADV_OFS, {16'h0, adv});
        apb(1'b1, an_arb_pkg::CTRL_OFS, {28'h0, ctl});
        injectErr <= 1'b1;
        repeat (5) @(posedge clk_sys);
        injectErr <= 1'b0;
        syncOk <= 1'b1;
        waitLink(1'b0);
        waitLink(1'b1);
        fd = adv[5] & pa[5];
        hd = !fd & adv[6] & pa[6];
        tx = adv[7] & pa[7] | !adv[7] & adv[8] & pa[7] & pa[8];
        rx = adv[7] & pa[7] | adv[7] & adv[8] & !pa[7] & pa[8];
        check({27'h0, resolved}, {27'h0, tx, rx, fd, hd, 1'b0});
        check({16'h0, seenWord}, {16'h0, adv & 16'h01E0 | {rf, 12'h0}});
    endtask
    initial begin
        logic [1:0] dup;
        int errBase;
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        // zeros must stand from reset through the enable state
        repeat (2) begin
            @(negedge clk_sys);
            check({16'h0, txConfigWord}, 32'h0);
        end
        @(posedge clk_sys);
        apb(1'b0, an_arb_pkg::ADV_OFS, 32'h0);
        check(rd, {16'h0, an_arb_pkg::ADV_RESET});
        apb(1'b0, an_arb_pkg::CTRL_OFS, 32'h0);
        check(rd, an_arb_pkg::CTRL_RESET);
        apb(1'b1, 12'h020, 32'hFFFF_FFFF);
        check({31'h0, errBit}, 32'h1);
        apb(1'b0, 12'h020, 32'h0);
        check(rd, 32'h0);
        // every pause pairing, partner duplex picked at random
        for (int k = 0; k < 16; k++) begin
            dup = 2'($random(seed));
            if (dup == 2'h0) dup = 2'h3;
            run({7'h0, 2'(k >> 2), 2'h3, 5'h0},
                {7'h0, 2'(k), dup, 5'h0}, 4'h5, 2'h0);
        end
        // each fault code is carried once, then cleared
        for (int c = 1; c < 4; c++) begin
            syncOk <= (c != 2);
            faultCode <= 2'(c);
            faultSensed <= 1'b1;
            @(posedge clk_sys);
            faultSensed <= 1'b0;
            run(16'h0060, 16'h0060, 4'h5, 2'(c));
        end
        run(16'h0060, 16'h0060, 4'h5, 2'h0);
        faultCode <= an_arb_pkg::RF_ANERR;
        faultSensed <= 1'b1;
        @(posedge clk_sys);
        faultSensed <= 1'b0;
        run(16'h0060, 16'h2060, 4'h1, 2'h0);
        apb(1'b0, an_arb_pkg::STAT_OFS, 32'h0);
        check({31'h0, rd[1]}, 32'h1);
        apb(1'b0, an_arb_pkg::STAT_OFS, 32'h0);
        check({31'h0, rd[1]}, 32'h0);
        // no shared duplex mode must be reported back as an error
        errBase = anErrSeen;
        pAbil <= 16'h0040;
        // bits outside the local ability mask must never be advertised
        apb(1'b1, an_arb_pkg::ADV_OFS, 32'h0000_0C20);
        apb(1'b0, an_arb_pkg::ADV_OFS, 32'h0);
        check(rd, 32'h0000_0020);
        apb(1'b1, an_arb_pkg::CTRL_OFS, 32'h0000_0005);
        for (int i = 0; i < 3000 && anErrSeen == errBase; i++) begin
            @(posedge clk_sys);
        end
        check({31'h0, anErrSeen != errBase}, 32'h1);
        wrap_up();
    end
endmodule
`default_nettype wire
